// >>> verilog/ddg_bank.sv
// APB register bank holding damping and low-rate gain settings for two loops.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "ddg_defs.svh"

module ddg_bank (
  // Clock, reset and enable
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Loop conditions
  input  wire ddg_pkg::ddg_loop_mode_type first_mode_i,
  input  wire ddg_pkg::ddg_loop_mode_type second_mode_i,
  // Settings to the loops
  output ddg_pkg::ddg_loop_cfg_type       first_cfg_o,
  output ddg_pkg::ddg_loop_cfg_type       second_cfg_o
);
  import ddg_pkg::*;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [7:0]  second_loop_damping_gain_r;
  logic [7:0]  second_loop_damping_gain_nxt;
  logic [7:0]  first_loop_damping_gain_r;
  logic [7:0]  first_loop_damping_gain_nxt;
  logic        second_auto_r;
  logic        second_auto_nxt;
  logic        first_auto_r;
  logic        first_auto_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        wr_en;
  logic [7:0]  wbyte;

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Keeps only the implemented fields of a damping register.
  function automatic logic [7:0] damp_mask(input logic [7:0] v);
    damp_mask = {1'b0, v[`DDG_GAIN_HI:`DDG_GAIN_LO], 1'b0, v[`DDG_DAMP_HI:`DDG_DAMP_LO]};
  endfunction

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Read data and error are prepared in the setup cycle so every bus output is a flop;
  // each access still completes in its first access cycle, with no wait state.
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt  = psel && !penable;
    if (psel && !penable) begin
      pslverr_nxt = 1'b0;
      prdata_nxt  = `DDG_ZERO32;
      if (hit(paddr, `DDG_IDX_SECOND_DAMP)) begin
        prdata_nxt[7:0] = second_loop_damping_gain_r;
      end else if (hit(paddr, `DDG_IDX_FIRST_DAMP)) begin
        prdata_nxt[7:0] = first_loop_damping_gain_r;
      end else if (hit(paddr, `DDG_IDX_SECOND_DGAIN)) begin
        prdata_nxt[`DDG_AUTO_BIT] = second_auto_r;
      end else if (hit(paddr, `DDG_IDX_FIRST_DGAIN)) begin
        prdata_nxt[`DDG_AUTO_BIT] = first_auto_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  assign wr_en = psel && penable && pready_r && pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    second_loop_damping_gain_nxt = second_loop_damping_gain_r;
    first_loop_damping_gain_nxt  = first_loop_damping_gain_r;
    second_auto_nxt              = second_auto_r;
    first_auto_nxt               = first_auto_r;
    if (wr_en) begin
      if (hit(paddr, `DDG_IDX_SECOND_DAMP)) begin
        second_loop_damping_gain_nxt = damp_mask(wbyte);
      end
      if (hit(paddr, `DDG_IDX_FIRST_DAMP)) begin
        first_loop_damping_gain_nxt = damp_mask(wbyte);
      end
      if (hit(paddr, `DDG_IDX_SECOND_DGAIN)) begin
        second_auto_nxt = wbyte[`DDG_AUTO_BIT];
      end
      if (hit(paddr, `DDG_IDX_FIRST_DGAIN)) begin
        first_auto_nxt = wbyte[`DDG_AUTO_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      second_loop_damping_gain_r <= `DDG_DAMP_RESET;
      first_loop_damping_gain_r  <= `DDG_DAMP_RESET;
      second_auto_r              <= `DDG_AUTO_RESET;
      first_auto_r               <= `DDG_AUTO_RESET;
      prdata_r                   <= `DDG_ZERO32;
      pready_r                   <= 1'b0;
      pslverr_r                  <= 1'b0;
    end else if (ce_i) begin
      second_loop_damping_gain_r <= second_loop_damping_gain_nxt;
      first_loop_damping_gain_r  <= first_loop_damping_gain_nxt;
      second_auto_r              <= second_auto_nxt;
      first_auto_r               <= first_auto_nxt;
      prdata_r                   <= prdata_nxt;
      pready_r                   <= pready_nxt;
      pslverr_r                  <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // --------------------------------------------------------------------------
  // Per-loop selection
  // --------------------------------------------------------------------------
  ddg_gain_sel u_second (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .damp_reg_i     (second_loop_damping_gain_r),
    .auto_gain_en_i (second_auto_r),
    .mode_i         (second_mode_i),
    .cfg_o          (second_cfg_o)
  );

  ddg_gain_sel u_first (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .damp_reg_i     (first_loop_damping_gain_r),
    .auto_gain_en_i (first_auto_r),
    .mode_i         (first_mode_i),
    .cfg_o          (first_cfg_o)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // The loop outputs still hold their reset value one edge after release, so the
  // antecedents that look back a cycle start only once reset was low at the edge.
  second_gain_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i && ce_i ##1 ce_i |-> second_cfg_o.low_rate_analog_gain ==
                                $past(second_loop_damping_gain_r[`DDG_GAIN_HI:`DDG_GAIN_LO]))
    else $error("second loop gain does not follow its register field");

  second_apply_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && !(second_auto_r && second_mode_i.ref_le_8k && second_mode_i.analog_fb)
      |=> !second_cfg_o.gain_apply)
    else $error("second loop gain applied without automatic selection at low rate");

  first_apply_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i && ce_i && first_auto_r && first_mode_i.ref_le_8k && first_mode_i.analog_fb
      |=> first_cfg_o.gain_apply)
    else $error("first loop gain not applied under automatic selection");

  first_gain_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i && ce_i |=> first_cfg_o.low_rate_analog_gain ==
                       $past(first_loop_damping_gain_r[`DDG_GAIN_HI:`DDG_GAIN_LO]))
    else $error("first loop gain does not follow its register field");

  auto_readback_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && psel && !penable && hit(paddr, `DDG_IDX_SECOND_DGAIN)
      |=> prdata[`DDG_AUTO_BIT] == $past(second_auto_r))
    else $error("second loop automatic gain enable reads back wrong");

  damp_write_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && wr_en && hit(paddr, `DDG_IDX_FIRST_DAMP) ##1 ce_i [*2]
      |-> first_cfg_o.damping_select == $past(wbyte[`DDG_DAMP_HI:`DDG_DAMP_LO], 2))
    else $error("first loop damping select not delivered two cycles after write");

  unused_bits_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    pready && !pslverr |-> prdata[31:8] == 24'h000000 && !prdata[3] &&
                           (prdata[7] == 1'b0 || !($past(hit(paddr, `DDG_IDX_SECOND_DAMP)) ||
                                                   $past(hit(paddr, `DDG_IDX_FIRST_DAMP)))))
    else $error("unused damping bits read back nonzero");

  unused_store_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !second_loop_damping_gain_r[`DDG_UNUSED_HI] && !second_loop_damping_gain_r[`DDG_UNUSED_LO] &&
    !first_loop_damping_gain_r[`DDG_UNUSED_HI] && !first_loop_damping_gain_r[`DDG_UNUSED_LO])
    else $error("unused damping bits stored");

  reserved_flag_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i && ce_i |=> first_cfg_o.damping_reserved ==
                       ($past(first_loop_damping_gain_r[`DDG_DAMP_HI:`DDG_DAMP_LO]) inside
                        {`DDG_DAMP_RSV0, `DDG_DAMP_RSV6, `DDG_DAMP_RSV7}))
    else $error("first loop reserved damping code not flagged");

  unmapped_error_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && psel && !penable && !hit(paddr, `DDG_IDX_SECOND_DAMP) && !hit(paddr, `DDG_IDX_FIRST_DAMP) &&
      !hit(paddr, `DDG_IDX_SECOND_DGAIN) && !hit(paddr, `DDG_IDX_FIRST_DGAIN)
      |=> pready && pslverr && prdata == `DDG_ZERO32)
    else $error("unmapped access not refused");

endmodule

// >>> verilog/ddg_defs.svh
// Register indices, field positions and reset values for the loop damping and gain bank.
`ifndef DDG_DEFS_SVH
`define DDG_DEFS_SVH

// --------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------------------
`define DDG_IDX_SECOND_DAMP   10'h06a
`define DDG_IDX_FIRST_DAMP    10'h06b
`define DDG_IDX_SECOND_DGAIN  10'h06c
`define DDG_IDX_FIRST_DGAIN   10'h06d

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define DDG_GAIN_HI     6
`define DDG_GAIN_LO     4
`define DDG_DAMP_HI     2
`define DDG_DAMP_LO     0
`define DDG_AUTO_BIT    7

// --------------------------------------------------------------------------
// Reset values and codes
// --------------------------------------------------------------------------
`define DDG_DAMP_RESET   8'h13
`define DDG_AUTO_RESET   1'b1
`define DDG_UNUSED_HI    7
`define DDG_UNUSED_LO    3
`define DDG_DGAIN_RESET  8'hc2
`define DDG_DAMP_RSV0    3'h0
`define DDG_DAMP_RSV6    3'h6
`define DDG_DAMP_RSV7    3'h7
`define DDG_ZERO32       32'h0000_0000

`endif

// >>> verilog/ddg_pkg.sv
// Types shared by the loop damping and gain bank.
package ddg_pkg;

  // Loop conditions reported by a loop's own logic.
  typedef struct packed {
    logic ref_le_8k;
    logic analog_fb;
  } ddg_loop_mode_type;

  // Settings presented to one loop.
  typedef struct packed {
    logic [2:0] damping_select;
    logic       damping_reserved;
    logic [2:0] low_rate_analog_gain;
    logic       gain_apply;
  } ddg_loop_cfg_type;

endpackage

// >>> verilog/ddg_gain_sel.sv
// Per-loop selection of the low-rate analog detector gain and damping code.
`timescale 1ns/1ps
`include "ddg_defs.svh"

module ddg_gain_sel (
  // Clock, reset and enable
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // Register contents
  input  wire logic [7:0]                 damp_reg_i,
  input  wire logic                       auto_gain_en_i,
  // Loop condition
  input  wire ddg_pkg::ddg_loop_mode_type mode_i,
  // Settings to the loop
  output ddg_pkg::ddg_loop_cfg_type       cfg_o
);
  import ddg_pkg::*;

  ddg_loop_cfg_type cfg_r;
  ddg_loop_cfg_type cfg_nxt;

  always_comb begin
    cfg_nxt                      = cfg_r;
    cfg_nxt.damping_select       = damp_reg_i[`DDG_DAMP_HI:`DDG_DAMP_LO];
    cfg_nxt.damping_reserved     = (damp_reg_i[`DDG_DAMP_HI:`DDG_DAMP_LO] == `DDG_DAMP_RSV0) ||
                                   (damp_reg_i[`DDG_DAMP_HI:`DDG_DAMP_LO] == `DDG_DAMP_RSV6) ||
                                   (damp_reg_i[`DDG_DAMP_HI:`DDG_DAMP_LO] == `DDG_DAMP_RSV7);
    // The field only steers the loop under automatic selection at low reference rates.
    cfg_nxt.gain_apply           = auto_gain_en_i && mode_i.ref_le_8k && mode_i.analog_fb;
    cfg_nxt.low_rate_analog_gain = damp_reg_i[`DDG_GAIN_HI:`DDG_GAIN_LO];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= '0;
    end else if (ce_i) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg_o = cfg_r;

endmodule

// >>> test/tb.sv
// Self-checking bench for the loop damping and gain register bank.
`timescale 1ns/1ps
`include "ddg_defs.svh"

module tb;
  import ddg_pkg::*;

  // --------------------------------------------------------------------------
  // Stimulus and observation
  // --------------------------------------------------------------------------
  logic              core_clk_i    = 1'b0;
  logic              rst_i         = 1'b1;
  logic              ce_i          = 1'b1;
  logic              psel          = 1'b0;
  logic              penable       = 1'b0;
  logic              pwrite        = 1'b0;
  logic [11:0]       paddr         = 12'h000;
  logic [31:0]       pwdata        = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ddg_loop_mode_type first_mode_i  = '0;
  ddg_loop_mode_type second_mode_i = '0;
  ddg_loop_cfg_type  first_cfg_o;
  ddg_loop_cfg_type  second_cfg_o;
  int                err_count     = 0;
  int                compares      = 0;
  logic [31:0]       rd;
  logic              er;

  localparam logic [11:0] A_SD  = {`DDG_IDX_SECOND_DAMP, 2'b00};
  localparam logic [11:0] A_FD  = {`DDG_IDX_FIRST_DAMP, 2'b00};
  localparam logic [11:0] A_SG  = {`DDG_IDX_SECOND_DGAIN, 2'b00};
  localparam logic [11:0] A_FG  = {`DDG_IDX_FIRST_DGAIN, 2'b00};
  localparam logic [11:0] A_BAD = 12'h1b8;

  ddg_bank ddg_bank_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_mode_i(first_mode_i), .second_mode_i(second_mode_i), .first_cfg_o(first_cfg_o),
    .second_cfg_o(second_cfg_o));

  always #4 core_clk_i = ~core_clk_i;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic finish_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cfg(input ddg_loop_cfg_type got, input ddg_loop_cfg_type exp, input string what);
    chk({24'h0, got}, {24'h0, exp}, what);
  endtask

  // Reserved damping codes are flagged so the loop can ignore them.
  function automatic ddg_loop_cfg_type ec(input logic [2:0] d, input logic [2:0] g, input logic a);
    return {d, (d == 3'h0 || d > 3'h5), g, a};
  endfunction

  // The master never assumes a latency; only the watchdog below ends a wait.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    settle();
    chk_cfg(second_cfg_o, ec(3'h3, 3'h1, 1'b0), "second cfg at reset");
    chk_cfg(first_cfg_o, ec(3'h3, 3'h1, 1'b0), "first cfg at reset");
    apb(A_SD, 1'b0, 32'h0);
    chk(rd, 32'h13, "second damp reset");
    chk({31'h0, er}, 32'h0, "second damp read err");
    apb(A_FD, 1'b0, 32'h0);
    chk(rd, 32'h13, "first damp reset");
    apb(A_SG, 1'b0, 32'h0);
    chk(rd, 32'h80, "second auto reset");
    apb(A_FG, 1'b0, 32'h0);
    chk(rd, 32'h80, "first auto reset");
  endtask

  task automatic t_fields();
    apb(A_SD, 1'b1, 32'hffff_ffff);
    apb(A_SD, 1'b0, 32'h0);
    chk(rd, 32'h77, "unused bits");
    settle();
    chk_cfg(second_cfg_o, ec(3'h7, 3'h7, 1'b0), "second all ones");
    chk_cfg(first_cfg_o, ec(3'h3, 3'h1, 1'b0), "first untouched");
  endtask

  task automatic t_apply();
    apb(A_SD, 1'b1, 32'h25);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk_i);
      second_mode_i <= m[1:0];
      settle();
      chk_cfg(second_cfg_o, ec(3'h5, 3'h2, m == 3), "second mode");
    end
    apb(A_SG, 1'b1, 32'h0);
    settle();
    chk_cfg(second_cfg_o, ec(3'h5, 3'h2, 1'b0), "second auto off");
    apb(A_SG, 1'b1, 32'h80);
    settle();
    chk_cfg(second_cfg_o, ec(3'h5, 3'h2, 1'b1), "second auto on");
    @(posedge core_clk_i);
    first_mode_i <= 2'b11;
    apb(A_FD, 1'b1, 32'h54);
    settle();
    chk_cfg(first_cfg_o, ec(3'h4, 3'h5, 1'b1), "first apply");
    apb(A_FG, 1'b1, 32'h0);
    settle();
    chk_cfg(first_cfg_o, ec(3'h4, 3'h5, 1'b0), "first auto off");
    apb(A_FG, 1'b1, 32'h80);
  endtask

  // A low enable must freeze the loop settings even though the loop conditions move.
  task automatic t_enable();
    @(posedge core_clk_i);
    ce_i          <= 1'b0;
    second_mode_i <= 2'b00;
    settle();
    chk_cfg(second_cfg_o, ec(3'h5, 3'h2, 1'b1), "frozen by enable");
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    settle();
    chk_cfg(second_cfg_o, ec(3'h5, 3'h2, 1'b0), "released by enable");
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      apb(A_FD, 1'b1, {25'h0, 3'h2, 1'b0, c[2:0]});
      settle();
      chk_cfg(first_cfg_o, ec(c[2:0], 3'h2, 1'b1), "damping code");
    end
  endtask

  task automatic t_bad();
    apb(A_BAD, 1'b1, 32'hff);
    chk({31'h0, er}, 32'h1, "unmapped write err");
    apb(A_SD + 12'h1, 1'b1, 32'h0);
    chk({31'h0, er}, 32'h1, "misaligned err");
    apb(A_BAD, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({31'h0, er}, 32'h1, "unmapped read err");
    apb(A_SD, 1'b0, 32'h0);
    chk(rd, 32'h25, "kept after refusal");
    chk({31'h0, er}, 32'h0, "mapped read err");
  endtask

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_apply();
    t_enable();
    t_codes();
    t_bad();
    finish_test();
  end

  // A full run takes well under a thousand cycles.
  initial begin
    #(8 * 5000);
    err_count++;
    finish_test();
  end
endmodule
